// ==== core/ext_irq_ctrl.sv ====
// external pin interrupt controller: three lines, enables, pending flags, wake
// assumes cpu signals (global enable, acks, io clock run) share sys_clk_in
//
// How it works
// - pins detected even when driven as outputs
// - third line is edge only
// - low level requests while pin stays low
// - lines a/b edges need running io clock
// - level and line c work while asleep
// - level wake needs two watchdog samples
// - vanished level wakes but no request
// - line b sense field bits 3:2
// - line a sense field bits 1:0
// - pins sampled before edge detection
// - line c polarity bit 6, 0 falling
// - line c catches pulses over 50 ns
// - line enabled by own bit and global
// - each line has its own request
// - flags at bits 7,6,5, rest zero
// - flag set on event, cleared ack/one
// - flag forced clear in level mode
`timescale 1ns/100ps
module ext_irq_ctrl
#(
  parameter int STARTUP_CYCLES = ext_irq_pkg::STARTUP_CYCLES
)
(
  input  wire logic                      sys_clk_in,  // system clock
  input  wire logic                      rst_in,      // async reset, active high
  input  wire ext_irq_pkg::reg_req_type  reg_req_in,  // register access
  output logic [ext_irq_pkg::DATA_W-1:0] rd_data_out, // read data, cycle after read
  input  wire logic [2:0]                line_pin_in, // pins: 0 a, 1 b, 2 c
  input  wire logic                      wdt_clk_in,  // watchdog oscillator clock
  input  wire logic                      gie_in,      // global interrupt enable
  input  wire logic                      io_run_in,   // io clock running
  input  wire logic                      pdown_in,    // in power-down sleep
  input  wire logic [2:0]                irq_ack_in,  // handler entered, per line
  output logic [2:0]                     irq_req_out, // request per vector
  output logic                           wake_out     // one-cycle wake pulse
);

  localparam int CNT_W = (STARTUP_CYCLES > 1) ? $clog2(STARTUP_CYCLES) : 1;

  // refuse settings the logic cannot serve
  if (STARTUP_CYCLES < 1)
  begin : g_bad_startup
    $error("STARTUP_CYCLES must be at least one");
  end
  if (ext_irq_pkg::SYNC_LATENCY >= ext_irq_pkg::MIN_PULSE_CYCLES)
  begin : g_bad_sync
    $error("sync latency too long for the minimum pulse");
  end

  logic [7:0]             ctrl_q;
  logic                   pol_c_q;
  logic [2:0]             en_q;
  logic [2:0]             flag_q;
  logic [2:0]             flag_d;
  logic [2:0]             irq_req_q;
  logic [2:0]             irq_req_d;
  logic                   wake_q;
  logic                   wake_d;
  logic [7:0]             rd_data_q;
  logic [CNT_W-1:0]       start_cnt_q;
  ext_irq_pkg::wake_state_type wk_q;

  logic [3:0]             raw_pins;
  logic [3:0]             lvl;
  logic [3:0]             rise;
  logic [3:0]             fall;
  logic [2:0]             level_mode;
  logic [2:0]             edge_ev;
  logic [2:0]             clr;
  logic [2:0]             armed;
  logic                   level_low;
  logic                   wdt_tick;
  ext_irq_pkg::sense_type sense_a;
  ext_irq_pkg::sense_type sense_b;

  logic wr_ctrl;
  logic wr_stat;
  logic wr_en;
  logic wr_flag;

  assign wr_ctrl = reg_req_in.wr && reg_req_in.addr == ext_irq_pkg::OFF_CONTROL;
  assign wr_stat = reg_req_in.wr && reg_req_in.addr == ext_irq_pkg::OFF_CONTROL_STATUS;
  assign wr_en   = reg_req_in.wr && reg_req_in.addr == ext_irq_pkg::OFF_ENABLE;
  assign wr_flag = reg_req_in.wr && reg_req_in.addr == ext_irq_pkg::OFF_FLAGS;

  // pad level, whoever drives it
  assign raw_pins = {wdt_clk_in, line_pin_in};

  // sample every pin before looking at edges
  for (genvar i = 0; i < 4; i++)
  begin : g_pin
    pin_sampler u_sampler
    (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .pin_in     (raw_pins[i]),
      .level_out  (lvl[i]),
      .rise_out   (rise[i]),
      .fall_out   (fall[i])
    );
  end

  assign wdt_tick = rise[3];

  assign sense_a = ext_irq_pkg::sense_type'(ctrl_q[ext_irq_pkg::SENSE_A_LSB +: 2]);
  assign sense_b = ext_irq_pkg::sense_type'(ctrl_q[ext_irq_pkg::SENSE_B_LSB +: 2]);

  function automatic logic sense_hit(ext_irq_pkg::sense_type s, logic r, logic f);
    logic hit;
    hit = 1'b0;
    unique case (s)
      ext_irq_pkg::SENSE_LOW:  hit = 1'b0;
      ext_irq_pkg::SENSE_ANY:  hit = r | f;
      ext_irq_pkg::SENSE_FALL: hit = f;
      ext_irq_pkg::SENSE_RISE: hit = r;
    endcase
    return hit;
  endfunction

  // line c never runs in level mode
  assign level_mode = {1'b0, sense_b == ext_irq_pkg::SENSE_LOW,
                       sense_a == ext_irq_pkg::SENSE_LOW};

  // a/b edges need the io clock; line c does not
  assign edge_ev[0] = io_run_in & sense_hit(sense_a, rise[0], fall[0]);
  assign edge_ev[1] = io_run_in & sense_hit(sense_b, rise[1], fall[1]);
  assign edge_ev[2] = pol_c_q ? rise[2] : fall[2];

  // line's own bit and the global bit
  assign armed = en_q & {3{gie_in}};

  // flag layout: bit 7 b, bit 6 a, bit 5 c
  assign clr = irq_ack_in | {reg_req_in.wdata[ext_irq_pkg::LINE_C_BIT] & wr_flag,
                             reg_req_in.wdata[ext_irq_pkg::LINE_B_BIT] & wr_flag,
                             reg_req_in.wdata[ext_irq_pkg::LINE_A_BIT] & wr_flag};

  // set wins over clear; level mode holds the flag clear
  assign flag_d = ~level_mode & (edge_ev | (flag_q & ~clr));

  // armed level line held low, for wake-up sampling
  assign level_low = |(armed[1:0] & level_mode[1:0] & ~lvl[1:0]);

  // level requests are held back until wake-up completes
  assign irq_req_d = armed & ((level_mode & ~lvl[2:0] &
                              {3{wk_q == ext_irq_pkg::WK_IDLE}}) |
                              flag_d);

  assign wake_d = (wk_q == ext_irq_pkg::WK_SAMPLE && wdt_tick && level_low) |
                  (pdown_in & armed[2] & edge_ev[2]);

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      ctrl_q <= ext_irq_pkg::CONTROL_RESET;
    else if (wr_ctrl)
      ctrl_q <= reg_req_in.wdata;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      pol_c_q <= 1'b0;
    else if (wr_stat)
      pol_c_q <= reg_req_in.wdata[ext_irq_pkg::POLARITY_C_BIT];
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      en_q <= 3'h0;
    else if (wr_en)
      en_q <= {reg_req_in.wdata[ext_irq_pkg::LINE_C_BIT],
               reg_req_in.wdata[ext_irq_pkg::LINE_B_BIT],
               reg_req_in.wdata[ext_irq_pkg::LINE_A_BIT]};
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      flag_q <= ext_irq_pkg::FLAGS_RESET;
    else
      flag_q <= flag_d;
  end

  // each line drives its own vector request
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_req_q <= 3'h0;
    else
      irq_req_q <= irq_req_d;
  end

  // two watchdog samples, then start-up time
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wk_q        <= ext_irq_pkg::WK_IDLE;
      start_cnt_q <= '0;
    end
    else
    begin
      unique case (wk_q)
        ext_irq_pkg::WK_IDLE:
        begin
          start_cnt_q <= '0;
          if (pdown_in && wdt_tick && level_low)
            wk_q <= ext_irq_pkg::WK_SAMPLE;
        end
        ext_irq_pkg::WK_SAMPLE:
        begin
          if (wdt_tick)
            wk_q <= level_low ? ext_irq_pkg::WK_START : ext_irq_pkg::WK_IDLE;
        end
        ext_irq_pkg::WK_START:
        begin
          if (start_cnt_q == CNT_W'(STARTUP_CYCLES - 1))
            wk_q <= ext_irq_pkg::WK_IDLE;
          else
            start_cnt_q <= start_cnt_q + 1'b1;
        end
        default:
          wk_q <= ext_irq_pkg::WK_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      wake_q <= 1'b0;
    else
      wake_q <= wake_d;
  end

  // read data stands one cycle only; unmapped reads zero
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      rd_data_q <= 8'h00;
    else if (reg_req_in.rd)
    begin
      unique case (reg_req_in.addr)
        ext_irq_pkg::OFF_CONTROL:        rd_data_q <= ctrl_q;
        ext_irq_pkg::OFF_CONTROL_STATUS: rd_data_q <= {1'b0, pol_c_q, 6'h00};
        ext_irq_pkg::OFF_ENABLE:         rd_data_q <= {en_q[1], en_q[0], en_q[2], 5'h00};
        ext_irq_pkg::OFF_FLAGS:          rd_data_q <= {flag_q[1], flag_q[0], flag_q[2],
                                                       5'h00};
        default:                         rd_data_q <= 8'h00;
      endcase
    end
    else
      rd_data_q <= 8'h00;
  end

  assign rd_data_out = rd_data_q;
  assign irq_req_out = irq_req_q;
  assign wake_out    = wake_q;

  // checks
  flag_c_set_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    edge_ev[2] |=> flag_q[2])
    else $error("line c event did not set its flag");

  flag_clear_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    flag_q[2] && irq_ack_in[2] && !edge_ev[2] |=> !flag_q[2] && !irq_req_out[2])
    else $error("acknowledged flag did not clear");

  level_flag_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    level_mode[0] || level_mode[1] |=> (flag_q[1:0] & $past(level_mode[1:0])) == 2'b00)
    else $error("flag set while line in level mode");

  level_req_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    armed[0] && level_mode[0] && !lvl[0] && wk_q == ext_irq_pkg::WK_IDLE
    |=> irq_req_out[0])
    else $error("held low level gave no request");

  global_gate_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !gie_in |=> irq_req_out == 3'h0)
    else $error("request raised with global enable clear");

  io_halt_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !io_run_in && !flag_q[1] |=> !flag_q[1])
    else $error("line b edge seen with io clock halted");

  sense_b_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    io_run_in && ctrl_q[3:2] == 2'b10 && fall[1] |=> flag_q[1])
    else $error("line b falling edge missed");

  pin_delay_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    io_run_in && ctrl_q[1:0] == 2'b11 && !line_pin_in[0] ##1 line_pin_in[0] [*3]
    |=> flag_q[0])
    else $error("sampled rising edge on line a missed");

  polarity_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    pol_c_q && fall[2] && !flag_q[2] |=> !flag_q[2])
    else $error("line c took wrong edge");

  startup_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wk_q == ext_irq_pkg::WK_START |=> (irq_req_out[1:0] & $past(level_mode[1:0])) == 2'b00)
    else $error("level request during start-up");

  wake_two_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(wk_q == ext_irq_pkg::WK_START) |-> $past(wk_q == ext_irq_pkg::WK_SAMPLE) && wake_out)
    else $error("start-up entered without second sample");

  regread_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    reg_req_in.rd && reg_req_in.addr == ext_irq_pkg::OFF_FLAGS
    |=> rd_data_out == {$past(flag_q[1]), $past(flag_q[0]), $past(flag_q[2]), 5'h00})
    else $error("flag register read wrong");

  edge_req_c: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    armed[2] && edge_ev[2] ##1 irq_req_out[2]);
  level_wake_c: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    wk_q == ext_irq_pkg::WK_START ##1 wk_q == ext_irq_pkg::WK_IDLE);
  any_change_c: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    sense_a == ext_irq_pkg::SENSE_ANY && io_run_in && fall[0]);
  write_clear_c: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    wr_flag && flag_q != 3'h0);

endmodule // ext_irq_ctrl

// ==== core/ext_irq_pkg.sv ====
// constants, register map and types for the external pin interrupt block
// assumes one 250 MHz clock and a plain strobe register port
package ext_irq_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int NUM_LINES = 3;

  // register offsets on the plain register port
  localparam logic [2:0] OFF_CONTROL        = 3'h0;
  localparam logic [2:0] OFF_CONTROL_STATUS = 3'h1;
  localparam logic [2:0] OFF_ENABLE         = 3'h2;
  localparam logic [2:0] OFF_FLAGS          = 3'h3;

  // field positions
  localparam int SENSE_A_LSB     = 0;
  localparam int SENSE_B_LSB     = 2;
  localparam int POLARITY_C_BIT  = 6;
  localparam int LINE_B_BIT      = 7;
  localparam int LINE_A_BIT      = 6;
  localparam int LINE_C_BIT      = 5;

  // values after reset
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET  = 8'h00;
  localparam logic [2:0] FLAGS_RESET   = 3'h0;

  // timing
  localparam int CLK_PERIOD_NS     = 4;
  localparam int MIN_PULSE_NS      = 50;
  localparam int MIN_PULSE_CYCLES  = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_LATENCY      = 3;
  localparam int STARTUP_CYCLES    = 16;

  typedef enum logic [1:0] {
    SENSE_LOW  = 2'b00,
    SENSE_ANY  = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } sense_type;

  typedef enum logic [1:0] {
    WK_IDLE,
    WK_SAMPLE,
    WK_START
  } wake_state_type;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_type;

endpackage

// ==== core/pin_sampler.sv ====
// two-stage synchroniser plus edge detector for one pin
// assumes the pin is asynchronous to sys_clk_in
`timescale 1ns/100ps
module pin_sampler
(
  input  wire logic sys_clk_in, // system clock
  input  wire logic rst_in,     // async reset, active high
  input  wire logic pin_in,     // raw pin level
  output logic      level_out,  // synchronised level
  output logic      rise_out,   // one-cycle pulse on rising edge
  output logic      fall_out    // one-cycle pulse on falling edge
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // first stage feeds only the second
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~prev_q;
  assign fall_out  = ~sync_q & prev_q;

endmodule // pin_sampler

// ==== sim/pin_board_model.sv ====
// board side: drives the three interrupt pads and the watchdog oscillator
// assumes set_pin is called just after a rising edge of sys_clk_in
`timescale 1ns/100ps
module pin_board_model
#(
  parameter int WDT_HALF_NS = 20
)
(
  input  wire logic  sys_clk_in,   // system clock
  output logic [2:0] line_pin_out, // pad levels, always driven
  output logic       wdt_clk_out   // free-running watchdog oscillator
);
  initial
  begin
    line_pin_out = 3'h7;
    wdt_clk_out  = 1'b0;
  end

  always #(WDT_HALF_NS) wdt_clk_out = ~wdt_clk_out;

  // level then held for hold cycles, 13 or more is past 50 ns
  task automatic set_pin(input int idx, input logic lvl, input int hold);
    line_pin_out[idx] <= lvl;
    repeat (hold) @(posedge sys_clk_in);
  endtask
endmodule // pin_board_model

// ==== sim/test_external_pin_interrupt_ctrl.sv ====
// self-checking bench for ext_irq_ctrl: register port, edge table, level, gating, wake
// assumes the pad model in pin_board_model.sv
`timescale 1ns/100ps
module test_external_pin_interrupt_ctrl;
  typedef struct packed {
    logic [1:0] line;
    logic [1:0] mode;
    logic       from_v;
    logic       to_v;
    logic       hit;
  } row_type;

  logic                    sys_clk = 1'b0;
  logic                    rst = 1'b1;
  ext_irq_pkg::reg_req_type req = '0;
  logic [7:0]              rd_data;
  logic [2:0]              pin;
  logic                    wdt_clk;
  logic                    gie = 1'b0;
  logic                    io_run = 1'b1;
  logic                    pdown = 1'b0;
  logic [2:0]              ack = 3'h0;
  logic [2:0]              irq;
  logic                    wake;
  int                      err_total = 0;
  int                      n_compared = 0;
  int                      cyc = 0;
  int                      wake_cnt = 0;
  int                      irqa_cnt = 0;
  int                      w0;
  row_type                 r;
  row_type                 rows [10] = '{
    '{2'd0, 2'b01, 1'b1, 1'b0, 1'b1}, '{2'd0, 2'b10, 1'b0, 1'b1, 1'b0},
    '{2'd0, 2'b11, 1'b0, 1'b1, 1'b1}, '{2'd0, 2'b10, 1'b1, 1'b0, 1'b1},
    '{2'd1, 2'b01, 1'b0, 1'b1, 1'b1}, '{2'd1, 2'b10, 1'b1, 1'b0, 1'b1},
    '{2'd1, 2'b11, 1'b1, 1'b0, 1'b0}, '{2'd2, 2'b00, 1'b1, 1'b0, 1'b1},
    '{2'd2, 2'b01, 1'b1, 1'b0, 1'b0}, '{2'd2, 2'b01, 1'b0, 1'b1, 1'b1}};

  always #2 sys_clk = ~sys_clk;

  ext_irq_ctrl #(.STARTUP_CYCLES(8)) dut
  (
    .sys_clk_in  (sys_clk),
    .rst_in      (rst),
    .reg_req_in  (req),
    .rd_data_out (rd_data),
    .line_pin_in (pin),
    .wdt_clk_in  (wdt_clk),
    .gie_in      (gie),
    .io_run_in   (io_run),
    .pdown_in    (pdown),
    .irq_ack_in  (ack),
    .irq_req_out (irq),
    .wake_out    (wake)
  );

  pin_board_model pins
  (
    .sys_clk_in   (sys_clk),
    .line_pin_out (pin),
    .wdt_clk_out  (wdt_clk)
  );

  // wake pulses seen, and cycles of line a request since the last wake
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (wake === 1'b1)
      wake_cnt <= wake_cnt + 1;
    if (wake === 1'b1)
      irqa_cnt <= 0;
    else if (irq[0] === 1'b1)
      irqa_cnt <= irqa_cnt + 1;
    if (cyc == 20000)
    begin
      err_total++;
      results();
    end
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge sys_clk);
    req.wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 check("rd_data", rd_data, exp);
    @(posedge sys_clk);
  endtask

  task automatic wait_wake();
    w0 = wake_cnt;
    for (int k = 0; k < 400 && wake_cnt == w0; k++)
      @(posedge sys_clk);
    check("wake", wake_cnt[7:0], w0[7:0] + 8'h01);
  endtask

  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    for (int a = 0; a < 6; a++)
      rd(a[2:0], 8'h00);
    wr(3'h0, 8'hF5);
    rd(3'h0, 8'hF5);
    wr(3'h1, 8'hFF);
    rd(3'h1, 8'h40);
    wr(3'h5, 8'hFF);
    rd(3'h5, 8'h00);
    wr(3'h2, 8'hE0);
    rd(3'h2, 8'hE0);
    gie <= 1'b1;
    foreach (rows[i])
    begin
      r = rows[i];
      pins.set_pin(r.line, r.from_v, 8);
      wr(3'h0, {4'h0, r.mode, r.mode});
      wr(3'h1, {1'b0, r.mode[0], 6'h00});
      wr(3'h3, 8'hE0);
      pins.set_pin(r.line, r.to_v, 14);
      rd(3'h3, {r.hit && r.line == 1, r.hit && r.line == 0, r.hit && r.line == 2, 5'h00});
      check("irq_line", {7'h00, irq[r.line]}, {7'h00, r.hit});
    end
    // low level on line a
    pins.set_pin(1, 1'b1, 4);
    wr(3'h0, 8'h00);
    wr(3'h3, 8'hE0);
    pins.set_pin(0, 1'b0, 40);
    check("level_irq", {5'h00, irq}, 8'h01);
    rd(3'h3, 8'h00);
    pins.set_pin(0, 1'b1, 8);
    check("level_off", {5'h00, irq}, 8'h00);
    // global enable gating with only line c enabled, then handler ack
    wr(3'h0, 8'h0A);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h20);
    gie <= 1'b0;
    wr(3'h3, 8'hE0);
    pins.set_pin(2, 1'b0, 14);
    rd(3'h3, 8'h20);
    check("gie_off", {5'h00, irq}, 8'h00);
    gie <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("gie_on", {5'h00, irq}, 8'h04);
    ack <= 3'h4;
    @(posedge sys_clk);
    ack <= 3'h0;
    repeat (3) @(posedge sys_clk);
    check("acked", {5'h00, irq}, 8'h00);
    rd(3'h3, 8'h00);
    // io clock stopped: line a edge lost, line c still caught
    wr(3'h2, 8'h00);
    wr(3'h1, 8'h40);
    wr(3'h3, 8'hE0);
    wr(3'h2, 8'hE0);
    io_run <= 1'b0;
    pins.set_pin(0, 1'b0, 14);
    pins.set_pin(2, 1'b1, 14);
    rd(3'h3, 8'h20);
    // power-down wake, level removed during start-up
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h40);
    pins.set_pin(0, 1'b1, 10);
    pdown <= 1'b1;
    pins.set_pin(0, 1'b0, 1);
    wait_wake();
    pins.set_pin(0, 1'b1, 30);
    pdown <= 1'b0;
    io_run <= 1'b1;
    repeat (10) @(posedge sys_clk);
    check("no_level", irqa_cnt[7:0], 8'h00);
    // power-down wake, level held past start-up
    io_run <= 1'b0;
    pdown <= 1'b1;
    pins.set_pin(0, 1'b0, 1);
    wait_wake();
    pdown <= 1'b0;
    repeat (30) @(posedge sys_clk);
    check("held_level", {7'h00, irq[0]}, 8'h01);
    // line c rising edge wakes from power-down
    wr(3'h2, 8'h20);
    wr(3'h3, 8'hE0);
    pins.set_pin(2, 1'b0, 8);
    pdown <= 1'b1;
    pins.set_pin(2, 1'b1, 1);
    wait_wake();
    pdown <= 1'b0;
    rd(3'h3, 8'h20);
    // reset in mid-run: outputs low, registers back to reset values
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1 check("reset_out", {4'h0, wake, irq}, 8'h00);
    @(posedge sys_clk);
    for (int a = 0; a < 4; a++)
      rd(a[2:0], 8'h00);
    results();
  end
endmodule // test_external_pin_interrupt_ctrl
